// file: src/spil_latch_top.v
// Short pulse input latch for two pulse I/O modules, four terminals each.
// Holds the pending and active input function of each terminal, the two
// status words that the scan reads, and an Avalon-MM slave for software.
// Assumes io_refresh_i and power_restart_i are one-cycle pulses from the
// controller, and that the pins may change at any time.
`timescale 1ns/1ps
`default_nettype none
`include "spil_consts.vh"

module spil_latch_top #(
    parameter NUM_TERM = 4,
    parameter NUM_MOD  = 2
) (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        mod0_term0_input_i,
    input  wire        mod0_term1_input_i,
    input  wire        mod0_term2_input_i,
    input  wire        mod0_term3_input_i,
    input  wire        mod1_term0_input_i,
    input  wire        mod1_term1_input_i,
    input  wire        mod1_term2_input_i,
    input  wire        mod1_term3_input_i,
    input  wire        io_refresh_i,
    input  wire        power_restart_i,
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [15:0] word_mod0_o,
    output reg  [15:0] word_mod1_o,
    output reg  [3:0]  ctr_phase_z_route_o,
    output reg  [7:0]  origin_route_o,
    output reg  [7:0]  interrupt_route_o
);

    localparam NUM_IN = NUM_TERM * NUM_MOD;
    localparam CFG_W  = NUM_IN * `SPIL_FUNC_W;

    ////////////////////////////////////////////////////////////////////////
    // Functions for the write check (legal_code) and the routing decode (func_of).

    // A code is legal for a terminal only if that terminal carries it:
    // counter phase Z exists on terminals 2 and 3 of each module alone.
    function legal_code;
        input [2:0] code;
        input [2:0] term;
        begin
            if (code == `SPIL_FUNC_NORMAL || code == `SPIL_FUNC_QUICK ||
                code == `SPIL_FUNC_INTERRUPT || code == `SPIL_FUNC_ORIGIN) begin
                legal_code = 1'b1;
            end else if (code == `SPIL_FUNC_CTR_Z) begin
                legal_code = term[1];
            end else begin
                legal_code = 1'b0;
            end
        end
    endfunction

    // Extract the function code of one input from a packed setting word.
    function [2:0] func_of;
        input [23:0] cfg;
        input [2:0]  idx;
        begin
            func_of = cfg[idx * 3 +: 3];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pins gathered into one vector, module 0 in the low half.
    wire [7:0] pins;
    assign pins = {mod1_term3_input_i, mod1_term2_input_i,
                   mod1_term1_input_i, mod1_term0_input_i,
                   mod0_term3_input_i, mod0_term2_input_i,
                   mod0_term1_input_i, mod0_term0_input_i};

    ////////////////////////////////////////////////////////////////////////
    // Setting registers. Software writes the pending copy; the active copy
    // steers the hardware and follows only at a power restart, so a half
    // typed setting can never reach the pins.
    reg  [CFG_W-1:0] cfg_pending_r;
    reg  [CFG_W-1:0] cfg_pending_nxt;
    reg  [CFG_W-1:0] cfg_active_r;
    wire             bus_req;
    wire             bus_take;
    wire [31:0]      wr_mask;
    wire [31:0]      wr_merged;

    assign bus_req  = avs_read | avs_write;
    assign bus_take = bus_req & ~avs_waitrequest;
    assign wr_mask  = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                       {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    assign wr_merged = (avs_writedata & wr_mask) |
                       ({8'h00, cfg_pending_r} & ~wr_mask);

    // Each field is checked alone; an illegal code keeps the old field so
    // a terminal always holds exactly one valid function.
    integer k;
    always @* begin
        cfg_pending_nxt = cfg_pending_r;
        if (bus_take && avs_write && avs_address == `SPIL_OFS_CFG_PENDING) begin
            for (k = 0; k < NUM_IN; k = k + 1) begin
                if (legal_code(wr_merged[k * 3 +: 3], k[2:0])) begin
                    cfg_pending_nxt[k * 3 +: 3] = wr_merged[k * 3 +: 3];
                end
            end
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_pending_r <= `SPIL_CFG_RESET;
        end else begin
            cfg_pending_r <= cfg_pending_nxt;
        end
    end

    // The active copy changes at a power restart and at nothing else.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_active_r <= `SPIL_CFG_RESET;
        end else if (power_restart_i) begin
            cfg_active_r <= cfg_pending_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decode of the active setting: which terminals capture, and which
    // other functions own a terminal instead.
    reg [7:0] qr_en;
    reg [7:0] normal_en;
    reg [7:0] int_en;
    reg [7:0] org_en;
    reg [3:0] ctrz_en;
    integer   j;
    always @* begin
        qr_en     = 8'h00;
        normal_en = 8'h00;
        int_en    = 8'h00;
        org_en    = 8'h00;
        for (j = 0; j < NUM_IN; j = j + 1) begin
            qr_en[j]     = (func_of(cfg_active_r, j[2:0]) == `SPIL_FUNC_QUICK);
            normal_en[j] = (func_of(cfg_active_r, j[2:0]) == `SPIL_FUNC_NORMAL);
            int_en[j]    = (func_of(cfg_active_r, j[2:0]) == `SPIL_FUNC_INTERRUPT);
            org_en[j]    = (func_of(cfg_active_r, j[2:0]) == `SPIL_FUNC_ORIGIN);
        end
        // Counter 1 and 0 on module 0 terminals 2 and 3, counters 3 and 2
        // on module 1 terminals 2 and 3.
        ctrz_en[1] = (func_of(cfg_active_r, 3'h2) == `SPIL_FUNC_CTR_Z);
        ctrz_en[0] = (func_of(cfg_active_r, 3'h3) == `SPIL_FUNC_CTR_Z);
        ctrz_en[3] = (func_of(cfg_active_r, 3'h6) == `SPIL_FUNC_CTR_Z);
        ctrz_en[2] = (func_of(cfg_active_r, 3'h7) == `SPIL_FUNC_CTR_Z);
    end

    ////////////////////////////////////////////////////////////////////////
    // One capture cell per eligible terminal; there are no others.
    wire [7:0] level;
    wire [7:0] report;

    genvar g;
    generate
        for (g = 0; g < NUM_IN; g = g + 1) begin : g_cell
            spil_capture_cell u_cell (
                .clk_i     (clk_i),
                .rst_n_i   (rst_n_i),
                .pin_i     (pins[g]),
                .qr_en_i   (qr_en[g]),
                .refresh_i (io_refresh_i),
                .flush_i   (power_restart_i),
                .level_o   (level[g]),
                .report_o  (report[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Status words. A quick terminal shows its held capture; a normal one
    // shows its level as taken at the refresh; a terminal owned by another
    // function reads zero. Bits above the four terminals read zero.
    reg  [7:0]  normal_snap_r;
    wire [7:0]  status;

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            normal_snap_r <= 8'h00;
        end else if (io_refresh_i) begin
            normal_snap_r <= level & normal_en;
        end
    end

    assign status = (report & qr_en) | (normal_snap_r & normal_en);

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            word_mod0_o <= `SPIL_WORD_RESET;
            word_mod1_o <= `SPIL_WORD_RESET;
        end else begin
            word_mod0_o <= {12'h000, status[3:0]};
            word_mod1_o <= {12'h000, status[7:4]};
        end
    end

    // Routing outputs tell the counter, origin search and interrupt logic
    // which terminals they own; a terminal set to quick gives all of them up.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctr_phase_z_route_o <= 4'h0;
            origin_route_o      <= 8'h00;
            interrupt_route_o   <= 8'h00;
        end else begin
            ctr_phase_z_route_o <= ctrz_en;
            origin_route_o      <= org_en;
            interrupt_route_o   <= int_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon slave. Every access waits exactly one cycle: waitrequest is
    // high in the first cycle of a request and low in the second, when the
    // write lands and the read data already stand. Unmapped reads give
    // zero and unmapped writes are dropped.
    reg [31:0] rd_mux;
    always @* begin
        if (avs_address == `SPIL_OFS_WORD_MOD0) begin
            rd_mux = {16'h0000, word_mod0_o};
        end else if (avs_address == `SPIL_OFS_WORD_MOD1) begin
            rd_mux = {16'h0000, word_mod1_o};
        end else if (avs_address == `SPIL_OFS_CFG_PENDING) begin
            rd_mux = {8'h00, cfg_pending_r};
        end else if (avs_address == `SPIL_OFS_CFG_ACTIVE) begin
            rd_mux = {8'h00, cfg_active_r};
        end else if (avs_address == `SPIL_OFS_ROUTING) begin
            rd_mux = {12'h000, interrupt_route_o, origin_route_o,
                      ctr_phase_z_route_o};
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
        end else begin
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_mux;
            end
        end
    end

endmodule // spil_latch_top

`default_nettype wire

// file: src/spil_consts.vh
// Constants for the short pulse input latch: register offsets, function
// codes, field positions and reset values.
// Assumes it is included by bare name from the design files under src/.
`ifndef SPIL_CONSTS_VH
`define SPIL_CONSTS_VH

// Avalon byte offsets of the register words.
`define SPIL_ADDR_W           5
`define SPIL_OFS_WORD_MOD0    5'h00
`define SPIL_OFS_WORD_MOD1    5'h04
`define SPIL_OFS_CFG_PENDING  5'h08
`define SPIL_OFS_CFG_ACTIVE   5'h0C
`define SPIL_OFS_ROUTING      5'h10

// Input word numbers that the two status words stand for.
`define SPIL_WORD_NUM_MOD0    16'h0B90
`define SPIL_WORD_NUM_MOD1    16'h0B92

// Input function codes, three bits per terminal.
`define SPIL_FUNC_W           3
`define SPIL_FUNC_NORMAL      3'h0
`define SPIL_FUNC_QUICK       3'h1
`define SPIL_FUNC_INTERRUPT   3'h2
`define SPIL_FUNC_CTR_Z       3'h3
`define SPIL_FUNC_ORIGIN      3'h4

// Field positions of the routing status word.
`define SPIL_ROUTE_CTR_LSB    0
`define SPIL_ROUTE_ORG_LSB    4
`define SPIL_ROUTE_INT_LSB    12

// Reset values.
`define SPIL_CFG_RESET        24'h000000
`define SPIL_WORD_RESET       16'h0000

// Least pulse width that is always caught, and its cycle count at 20 MHz.
`define SPIL_MIN_PULSE_NS     30000
`define SPIL_CLK_PERIOD_NS    50
`define SPIL_MIN_PULSE_CYC    ((`SPIL_MIN_PULSE_NS + `SPIL_CLK_PERIOD_NS - 1) / `SPIL_CLK_PERIOD_NS)

`endif

// file: src/spil_capture_cell.v
// One input terminal: synchroniser, rising edge detector, pulse latch and
// the status bit that the scan sees between two I/O refreshes.
// Assumes pin_i is asynchronous to clk_i and refresh_i is a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none

module spil_capture_cell (
    input  wire clk_i,
    input  wire rst_n_i,
    input  wire pin_i,
    input  wire qr_en_i,
    input  wire refresh_i,
    input  wire flush_i,
    output wire level_o,
    output wire report_o
);

    reg sync1_r;
    reg sync2_r;
    reg prev_r;
    reg cap_r;
    reg report_r;
    wire rise;

    ////////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser; only sync2_r reads sync1_r.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r  <= 1'b0;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    // Edge detection works on the settled copy only.
    assign rise    = sync2_r & ~prev_r;
    assign level_o = sync2_r;

    ////////////////////////////////////////////////////////////////////////
    // The latch catches an ON edge of any length the synchroniser can see,
    // so a 30 us pulse is far above what is needed. A new edge in the
    // refresh cycle sets the latch, so it is not lost to the clear.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            cap_r <= 1'b0;
        end else if (flush_i || !qr_en_i) begin
            cap_r <= 1'b0;
        end else if (rise) begin
            cap_r <= 1'b1;
        end else if (refresh_i) begin
            cap_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // The reported bit changes only at a refresh or a flush, so it stands for one
    // whole scan; the next refresh drops it unless a new edge came in or the pin is still ON.
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            report_r <= 1'b0;
        end else if (flush_i) begin
            report_r <= 1'b0;
        end else if (refresh_i) begin
            report_r <= qr_en_i & (cap_r | rise | sync2_r);
        end
    end

    assign report_o = report_r;

endmodule // spil_capture_cell

`default_nettype wire

// file: dv/spil_latch_properties.sv
// Port-level checker for the short pulse input latch.
// Assumes it is bound to spil_latch_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module spil_latch_properties (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        mod0_term0_input_i,
    input wire logic        io_refresh_i,
    input wire logic        power_restart_i,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [15:0] word_mod0_o,
    input wire logic [15:0] word_mod1_o,
    input wire logic [3:0]  ctr_phase_z_route_o,
    input wire logic [7:0]  origin_route_o,
    input wire logic [7:0]  interrupt_route_o
);
    // One clock domain, so one default clock and one reset mask.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_word_high_zero: assert property ((word_mod0_o[15:4] | word_mod1_o[15:4]) == 12'h000)
        else $error("status word upper bits set");
    chk_word_hold_scan: assert property (!$past(io_refresh_i) && !$past(io_refresh_i, 2)
        && !$past(power_restart_i) && !$past(power_restart_i, 2)
        |-> $stable({word_mod0_o, word_mod1_o})) else $error("status word moved between refreshes");
    chk_level_reported: assert property ((!origin_route_o[0] && !interrupt_route_o[0]
        && !power_restart_i && mod0_term0_input_i) [*4] ##0 io_refresh_i |=> ##1 word_mod0_o[0])
        else $error("held input not reported");
    chk_route_restart: assert property (!$past(power_restart_i) && !$past(power_restart_i, 2)
        |-> $stable({ctr_phase_z_route_o, origin_route_o, interrupt_route_o}))
        else $error("routing changed without restart");
    chk_route_exclusive: assert property ((origin_route_o & interrupt_route_o) == 8'h00)
        else $error("terminal has two functions");
    chk_ctr_terminal: assert property (|ctr_phase_z_route_o |-> (ctr_phase_z_route_o[0] ? !origin_route_o[3]
        : 1'b1) && (ctr_phase_z_route_o[3] ? !interrupt_route_o[6] : 1'b1))
        else $error("counter terminal also routed elsewhere");
    // The slave inserts exactly one wait cycle and then idles high.
    chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_rdata_hold: assert property (!($past(avs_read) && $past(avs_waitrequest)) |-> $stable(avs_readdata))
        else $error("read data changed without read");
endmodule // spil_latch_properties
bind spil_latch_top spil_latch_properties u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .mod0_term0_input_i(mod0_term0_input_i), .io_refresh_i(io_refresh_i),
    .power_restart_i(power_restart_i), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .word_mod0_o(word_mod0_o),
    .word_mod1_o(word_mod1_o), .ctr_phase_z_route_o(ctr_phase_z_route_o),
    .origin_route_o(origin_route_o), .interrupt_route_o(interrupt_route_o));
`default_nettype wire

// file: dv/spil_sensor_model.sv
// Sensor model: eight switching outputs, a held level per line plus one timed pulse.
// Assumes the bench asks for one pulse at a time, on the bench clock.
`timescale 1ns/1ps
`default_nettype none
module spil_sensor_model (
    input  wire logic        clk_i,
    input  wire logic [7:0]  level_i,
    input  wire logic        fire_i,
    input  wire logic [2:0]  idx_i,
    input  wire logic [15:0] width_i,
    output logic      [7:0]  pins_o
);
    logic [15:0] left_r = 16'h0000;
    logic [2:0]  sel_r = 3'h0;
    // A fired pulse stays ON for exactly width_i cycles, so its width is known.
    always @(posedge clk_i) begin
        if (fire_i) begin
            left_r <= width_i;
            sel_r  <= idx_i;
        end else if (left_r != 16'h0000) begin
            left_r <= left_r - 16'h0001;
        end
    end
    // An idle line shows the held level, never a stale pulse.
    assign pins_o = level_i | ((left_r != 16'h0000) ? (8'h01 << sel_r) : 8'h00);
endmodule // spil_sensor_model
`default_nettype wire

// file: dv/spil_latch_top_tb_top.sv
// Self-checking bench for the short pulse input latch with a reference model.
// Assumes the design sources under src/ and the sensor model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "spil_consts.vh"
module spil_latch_top_tb_top;
    logic        clk_i = 1'b0, rst_n_i = 1'b0, io_refresh_i = 1'b0, power_restart_i = 1'b0;
    logic        avs_read = 1'b0, avs_write = 1'b0, fire = 1'b0, avs_waitrequest;
    logic [4:0]  avs_address = 5'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [3:0]  avs_byteenable = 4'hF, ctr_phase_z_route_o;
    logic [15:0] word_mod0_o, word_mod1_o, width = 16'h0000;
    logic [7:0]  origin_route_o, interrupt_route_o, pins, level = 8'h00, lat = 8'h00, seen;
    logic [2:0]  idx = 3'h0;
    logic [23:0] pcfg = 24'h0, acfg = 24'h0;
    int          n_errors = 0, checks = 0, cyc = 0;
    spil_sensor_model u_sensor (.clk_i(clk_i), .level_i(level), .fire_i(fire), .idx_i(idx),
        .width_i(width), .pins_o(pins));
    spil_latch_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .mod0_term0_input_i(pins[0]),
        .mod0_term1_input_i(pins[1]), .mod0_term2_input_i(pins[2]), .mod0_term3_input_i(pins[3]),
        .mod1_term0_input_i(pins[4]), .mod1_term1_input_i(pins[5]), .mod1_term2_input_i(pins[6]),
        .mod1_term3_input_i(pins[7]), .io_refresh_i(io_refresh_i), .power_restart_i(power_restart_i),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .word_mod0_o(word_mod0_o), .word_mod1_o(word_mod1_o),
        .ctr_phase_z_route_o(ctr_phase_z_route_o), .origin_route_o(origin_route_o),
        .interrupt_route_o(interrupt_route_o));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("n_errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Holds the request until waitrequest is sampled low; the bench timeout ends a hang.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        avs_address <= a; avs_writedata <= d; avs_byteenable <= be;
        avs_write <= wr; avs_read <= !wr;
        @(posedge clk_i);
        while (avs_waitrequest !== 1'b0) @(posedge clk_i);
        rd = avs_readdata;
        avs_read <= 1'b0; avs_write <= 1'b0;
        @(posedge clk_i);
    endtask
    // Model: masked bytes land, an illegal function code keeps the old field.
    task automatic wcfg(input logic [23:0] v, input logic [3:0] be);
        logic [23:0] m;
        m = pcfg;
        for (int b = 0; b < 3; b++) if (be[b]) m[8*b +: 8] = v[8*b +: 8];
        // Counter phase Z exists on terminals 2 and 3 of each module alone.
        for (int k = 0; k < 8; k++)
            if (m[3*k +: 3] > 3'h4 || (m[3*k +: 3] == 3'h3 && (k % 4) < 2))
                m[3*k +: 3] = pcfg[3*k +: 3];
        pcfg = m;
        bus(1'b1, `SPIL_OFS_CFG_PENDING, {8'h00, v}, be);
        bus(1'b0, `SPIL_OFS_CFG_PENDING, 32'h0, 4'hF);
        check(rd, {8'h00, pcfg});
    endtask
    // Refresh: quick bits show latch or level, normal bits the level, others zero.
    task automatic refresh(input bit chk);
        logic [7:0] e;
        for (int k = 0; k < 8; k++) e[k] = (acfg[3*k +: 3] == `SPIL_FUNC_QUICK && lat[k])
            || (acfg[3*k +: 3] <= `SPIL_FUNC_QUICK && level[k]);
        io_refresh_i <= 1'b1;
        @(posedge clk_i);
        io_refresh_i <= 1'b0;
        lat = 8'h00;
        repeat (3) @(posedge clk_i);
        seen = {word_mod1_o[3:0], word_mod0_o[3:0]};
        if (chk) check({word_mod1_o, word_mod0_o}, {12'h0, e[7:4], 12'h0, e[3:0]});
    endtask
    task automatic pulse(input int k, input int w);
        idx <= k[2:0]; width <= w[15:0]; fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (w + 6) @(posedge clk_i);
        if (acfg[3*k +: 3] == `SPIL_FUNC_QUICK) lat[k] = 1'b1;
    endtask
    // Restart: pending becomes active; routing follows the counter terminal map.
    task automatic restart();
        logic [19:0] r;
        power_restart_i <= 1'b1;
        @(posedge clk_i);
        power_restart_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        acfg = pcfg; lat = 8'h00; r = 20'h0;
        for (int k = 0; k < 8; k++) r[4+k] = (acfg[3*k +: 3] == `SPIL_FUNC_ORIGIN);
        for (int k = 0; k < 8; k++) r[12+k] = (acfg[3*k +: 3] == `SPIL_FUNC_INTERRUPT);
        r[3:0] = {acfg[20:18] == 3'h3, acfg[23:21] == 3'h3, acfg[8:6] == 3'h3, acfg[11:9] == 3'h3};
        bus(1'b0, `SPIL_OFS_CFG_ACTIVE, 32'h0, 4'hF);
        check(rd, {8'h00, acfg});
        bus(1'b0, `SPIL_OFS_ROUTING, 32'h0, 4'hF);
        check(rd, {12'h0, r});
        check({ctr_phase_z_route_o, origin_route_o, interrupt_route_o}, {12'h0, r[3:0], r[11:4], r[19:12]});
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    // Hang guard: the run needs well under 20000 cycles.
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        logic [23:0] v;
        logic [4:0]  ofs [5] = '{`SPIL_OFS_CFG_PENDING, `SPIL_OFS_CFG_ACTIVE, `SPIL_OFS_ROUTING, 5'h14, 5'h1C};
        int          fn [8] = '{0, 2, 3, 3, 4, 1, 2, 4};
        void'($urandom(32'hA46C));
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b1, `SPIL_OFS_CFG_ACTIVE, 32'h00FFFFFF, 4'hF);
        bus(1'b1, 5'h14, 32'hFFFFFFFF, 4'hF);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0, 4'hF);
            check(rd, 32'h0);
        end
        // Pending write, byte lane mask, then a pulse that must not count before restart.
        wcfg(24'h249249, 4'hF);
        wcfg(24'h000000, 4'h2);
        wcfg(24'h249249, 4'hF);
        pulse(2, 600);
        refresh(1'b1);
        restart();
        // Every terminal: width from the 30 us floor, random above it except the first pulse on terminal 0, seen once, then cleared.
        for (int k = 0; k < 8; k++) begin
            pulse(k, (k == 0) ? 600 : 600 + $urandom_range(0, 63));
            if (k[0]) pulse(7 - k, 600 + $urandom_range(0, 63));
            refresh(1'b1);
            refresh(1'b1);
        end
        // A short pulse near the refresh edge is reported in one of two scans.
        for (int d = 0; d < 6; d++) begin
            idx <= 3'h2; width <= 16'h0028; fire <= 1'b1;
            @(posedge clk_i);
            fire <= 1'b0;
            repeat (d) @(posedge clk_i);
            refresh(1'b0);
            v[0] = seen[2];
            repeat (50) @(posedge clk_i);
            refresh(1'b0);
            check({31'h0, v[0] | seen[2]}, 32'h1);
            refresh(1'b1);
        end
        // Every function code, two illegal fields, and held levels per function.
        for (int k = 0; k < 8; k++) v[3*k +: 3] = fn[k][2:0];
        wcfg(v, 4'hF);
        v[5:3] = 3'h7;
        v[2:0] = 3'h3;
        wcfg(v, 4'hF);
        restart();
        level <= 8'hFF;
        repeat (8) @(posedge clk_i);
        refresh(1'b1);
        level <= 8'h00;
        repeat (8) @(posedge clk_i);
        refresh(1'b1);
        complete_run();
    end
endmodule // spil_latch_top_tb_top
`default_nettype wire
